// ==== core/rlbs_pkg.sv ====
// shared constants and carrier types of the redundant link block selector
package rlbs_pkg;

  // ********************************************************************
  // word and block limits
  // ********************************************************************
  localparam int unsigned WORD_W          = 16;
  localparam int unsigned CNT_W           = 8;
  localparam logic [7:0]  MAX_WORDS_RED   = 8'd59;
  localparam logic [7:0]  MAX_WORDS_STD   = 8'd200;
  localparam int unsigned TX_MEM_DEPTH    = 200;
  localparam int unsigned FIFO_DEPTH      = 16;

  // ********************************************************************
  // reset values
  // ********************************************************************
  localparam logic [15:0] SERIAL_RESET    = 16'h0000;
  localparam logic [7:0]  WORDS_RESET     = 8'h02;
  localparam logic [15:0] FLAGS_RESET     = 16'h0000;

  // ********************************************************************
  // timing
  // ********************************************************************
  localparam int unsigned CLK_MHZ           = 100;
  localparam int unsigned PER_STATION_US    = 2300;
  localparam int unsigned EXCHANGE_PERIOD_US = 20000;
  localparam int unsigned PERIOD_CYCLES =
    EXCHANGE_PERIOD_US * CLK_MHZ;

  // ********************************************************************
  // carriers
  // ********************************************************************
  typedef struct packed {
    logic        first;
    logic        last;
    logic [15:0] data;
  } rlbs_beat_t;

  typedef struct packed {
    logic       redundant;
    logic [7:0] words;
  } rlbs_cfg_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [15:0] data;
  } rlbs_wr_t;

  typedef enum logic {
    RLBS_TX_IDLE,
    RLBS_TX_SEND
  } rlbs_tx_state_t;

endpackage

// ==== core/rlbs_fifo.sv ====
// parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
module rlbs_fifo #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr;
  logic [AW:0]      rptr;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  // full when the pointers differ only in the wrap bit
  assign full      = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  assign empty     = (wptr == rptr);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rptr[AW-1:0]];
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (push) begin
        wptr <= wptr + 1'b1;
      end
      if (pop) begin
        rptr <= rptr + 1'b1;
      end
    end
  end

endmodule

// ==== core/rlbs_top.sv ====
// periodic block exchange over two redundant networks with copy selection
`timescale 1ns/1ps

// Overview of operation
// - a parameter download forces the link enable to disabled
// - link enable changes are taken only in stop mode, else refused
// - when enabled, blocks are sent and received per loaded parameters
// - block holds at most 59 words redundant, 200 words otherwise
// - in redundant use one serial word precedes the block data
// - redundant mode inserts serial on send, keeps it at word zero on receive
// - received partner serial is stored at the serial word position
// - own serial increments once per period in redundant mode only, aligned with the pair
// - of two copies starting in the same cycle only the larger serial is kept
// - a lone copy is saved only if its serial beats the held one
// - user link flags are the bitwise or of module a and b flags
// - both processors and modules run identical program and parameters
// - selector starts on enable rising edge, raises ok when done
module rlbs_top
  import rlbs_pkg::*;
#(
  parameter int unsigned PERIOD = PERIOD_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        cfg_load,
  input  wire rlbs_cfg_t   cfg_in,
  input  wire logic        ctrl_stop,
  input  wire logic        enable_req,
  input  wire logic        enable_value,
  input  wire logic        period_sync,
  input  wire logic        tx_wr_en,
  input  wire logic [7:0]  tx_wr_addr,
  input  wire logic [15:0] tx_wr_data,
  output logic             tx_valid,
  output rlbs_beat_t       tx_beat,
  input  wire logic        tx_ready,
  input  wire logic        rx_a_valid,
  input  wire rlbs_beat_t  rx_a_beat,
  input  wire logic        rx_b_valid,
  input  wire rlbs_beat_t  rx_b_beat,
  output rlbs_wr_t         rx_store,
  input  wire logic [15:0] flags_a,
  input  wire logic [15:0] flags_b,
  output logic [15:0]      link_flags,
  input  wire logic        sel_enable,
  input  wire logic [15:0] sel_serial_a,
  input  wire logic [15:0] sel_serial_b,
  output logic             sel_pick_b,
  output logic             selector_ok,
  output logic             link_enabled,
  output logic             enable_refused,
  output logic [15:0]      tx_serial,
  output logic [15:0]      rx_serial
);

  // ********************************************************************
  // helpers
  // ********************************************************************
  // half-range compare so the wrap to zero still counts as newer
  function automatic logic is_newer(input logic [15:0] cand,
                                    input logic [15:0] held);
    logic [15:0] diff;
    diff = cand - held;
    return (diff != 16'h0000) && !diff[15];
  endfunction

  function automatic logic [7:0] word_limit(input rlbs_cfg_t c);
    logic [7:0] cap;
    cap = c.redundant ? MAX_WORDS_RED : MAX_WORDS_STD;
    return (c.words > cap) ? cap : c.words;
  endfunction

  // ********************************************************************
  // configuration and link enable
  // ********************************************************************
  rlbs_cfg_t  cfg;
  logic [7:0] limit;

  assign limit = word_limit(cfg);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg <= '{redundant: 1'b1, words: WORDS_RESET};
    end else if (cfg_load) begin
      cfg <= cfg_in;
    end
  end

  // download beats a same-cycle enable request
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      link_enabled   <= 1'b0;
      enable_refused <= 1'b0;
    end else begin
      enable_refused <= 1'b0;
      if (cfg_load) begin
        link_enabled <= 1'b0;
      end else if (enable_req) begin
        if (ctrl_stop) begin
          link_enabled <= enable_value;
        end else begin
          enable_refused <= 1'b1;
        end
      end
    end
  end

  // ********************************************************************
  // exchange period and own serial
  // ********************************************************************
  logic [31:0] period_cnt;
  logic        period_tick;

  assign period_tick = link_enabled && (period_cnt == 32'(PERIOD - 1));

  // partner pulse restarts the period so both processors tick together
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      period_cnt <= '0;
    end else if (!link_enabled || period_sync || period_tick) begin
      period_cnt <= '0;
    end else begin
      period_cnt <= period_cnt + 32'd1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_serial <= SERIAL_RESET;
    end else if (period_tick && cfg.redundant) begin
      tx_serial <= tx_serial + 16'h0001;
    end
  end

  // ********************************************************************
  // transmit block memory and sequencer
  // ********************************************************************
  logic [15:0]    tx_mem [TX_MEM_DEPTH];
  rlbs_tx_state_t tx_state;
  logic [7:0]     tx_idx;
  logic [7:0]     tx_len;
  rlbs_beat_t     push_beat;
  logic           push_valid;
  logic           push_ready;
  logic [7:0]     mem_idx;

  always_ff @(posedge ref_clk) begin
    if (tx_wr_en && (tx_wr_addr < 8'(TX_MEM_DEPTH))) begin
      tx_mem[tx_wr_addr] <= tx_wr_data;
    end
  end

  // redundant frames carry one extra word, the serial, ahead of data
  assign tx_len  = cfg.redundant ? (limit + 8'd1) : limit;
  assign mem_idx = cfg.redundant ? (tx_idx - 8'd1) : tx_idx;

  always_comb begin
    push_valid = (tx_state == RLBS_TX_SEND);
    push_beat.first = (tx_idx == 8'd0);
    push_beat.last  = (tx_idx == tx_len - 8'd1);
    if (cfg.redundant && tx_idx == 8'd0) begin
      push_beat.data = tx_serial;
    end else begin
      // non-redundant: word zero is the serial the program wrote
      push_beat.data = tx_mem[mem_idx];
    end
  end

  // a period that lands while a frame is still being pushed into the fifo is skipped
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state <= RLBS_TX_IDLE;
      tx_idx   <= '0;
    end else begin
      case (tx_state)
        RLBS_TX_IDLE: begin
          if (period_tick && limit != 8'd0) begin
            tx_state <= RLBS_TX_SEND;
            tx_idx   <= '0;
          end
        end
        RLBS_TX_SEND: begin
          if (!link_enabled) begin
            tx_state <= RLBS_TX_IDLE;
          end else if (push_ready) begin
            if (push_beat.last) begin
              tx_state <= RLBS_TX_IDLE;
            end else begin
              tx_idx <= tx_idx + 8'd1;
            end
          end
        end
        default: begin
          tx_state <= RLBS_TX_IDLE;
        end
      endcase
    end
  end

  // ********************************************************************
  // transmit buffer and output register
  // ********************************************************************
  logic       fifo_out_valid;
  logic       fifo_out_ready;
  rlbs_beat_t fifo_out_data;

  rlbs_fifo #(
    .WIDTH ($bits(rlbs_beat_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_beat),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  assign fifo_out_ready = !tx_valid || tx_ready;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_valid <= 1'b0;
      tx_beat  <= '0;
    end else if (fifo_out_ready) begin
      tx_valid <= fifo_out_valid;
      if (fifo_out_valid) begin
        tx_beat <= fifo_out_data;
      end
    end
  end

  // ********************************************************************
  // receive selection between module a and module b
  // ********************************************************************
  logic       owned;
  logic       owner_b;
  logic [7:0] rx_cnt;
  logic [7:0] rx_top;
  logic       take_a;
  logic       take_b;
  logic       first_a;
  logic       first_b;
  logic       b_beats_a;
  logic       own_valid;
  rlbs_beat_t own_beat;

  // last stored address: redundant, serial at zero plus limit data words; otherwise limit words from zero
  assign rx_top = cfg.redundant ? limit : (limit - 8'd1);

  // one frame at a time owns the store; a copy arriving while owned is lost
  assign first_a = link_enabled && rx_a_valid && rx_a_beat.first && !owned;
  assign first_b = link_enabled && rx_b_valid && rx_b_beat.first && !owned;

  // copies starting together: larger serial wins, module a on a tie
  assign b_beats_a = first_b &&
                     is_newer(rx_b_beat.data, rx_a_beat.data);
  assign take_a = first_a && !b_beats_a &&
                  is_newer(rx_a_beat.data, rx_serial);
  assign take_b = first_b && !take_a &&
                  is_newer(rx_b_beat.data, rx_serial);

  assign own_valid = owner_b ? rx_b_valid : rx_a_valid;
  assign own_beat  = owner_b ? rx_b_beat : rx_a_beat;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      owned     <= 1'b0;
      owner_b   <= 1'b0;
      rx_cnt    <= '0;
      rx_serial <= SERIAL_RESET;
    end else if (cfg_load) begin
      owned     <= 1'b0;
      rx_serial <= SERIAL_RESET;
    end else if (take_a || take_b) begin
      owned     <= !(take_a ? rx_a_beat.last : rx_b_beat.last);
      owner_b   <= take_b;
      rx_cnt    <= 8'd1;
      rx_serial <= take_a ? rx_a_beat.data : rx_b_beat.data;
    end else if (owned && own_valid) begin
      rx_cnt <= rx_cnt + 8'd1;
      if (own_beat.last || own_beat.first) begin
        owned <= 1'b0;
      end
    end
  end

  // words past the block limit are dropped, except non-redundant with limit zero, where rx_top wraps to 255
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_store <= '0;
    end else begin
      rx_store.valid <= 1'b0;
      if (take_a || take_b) begin
        rx_store.valid <= 1'b1;
        rx_store.addr  <= 8'd0;
        rx_store.data  <= take_a ? rx_a_beat.data : rx_b_beat.data;
      end else if (owned && own_valid && !own_beat.first &&
                   rx_cnt <= rx_top) begin
        rx_store.valid <= 1'b1;
        rx_store.addr  <= rx_cnt;
        rx_store.data  <= own_beat.data;
      end
    end
  end

  // ********************************************************************
  // link information flags
  // ********************************************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      link_flags <= FLAGS_RESET;
    end else begin
      link_flags <= flags_a | flags_b;
    end
  end

  // ********************************************************************
  // latest copy selector
  // ********************************************************************
  logic sel_enable_d;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_enable_d <= 1'b0;
      sel_pick_b   <= 1'b0;
      selector_ok  <= 1'b0;
    end else begin
      sel_enable_d <= sel_enable;
      if (!sel_enable) begin
        selector_ok <= 1'b0;
      end else if (!sel_enable_d) begin
        sel_pick_b  <= is_newer(sel_serial_b, sel_serial_a);
        selector_ok <= 1'b1;
      end
    end
  end

endmodule

// ==== core/dummy_never.sv ====
// no module here: the block is its top module and its fifo alone

// ==== sim/rlbs_chk_sva.sv ====
// port checker of the redundant link block selector
`timescale 1ns/1ps
module rlbs_chk
  import rlbs_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        cfg_load,
  input wire rlbs_cfg_t   cfg_in,
  input wire logic        ctrl_stop,
  input wire logic        enable_req,
  input wire logic        enable_value,
  input wire logic        tx_valid,
  input wire rlbs_beat_t  tx_beat,
  input wire logic        tx_ready,
  input wire rlbs_wr_t    rx_store,
  input wire logic [15:0] flags_a,
  input wire logic [15:0] flags_b,
  input wire logic [15:0] link_flags,
  input wire logic        sel_enable,
  input wire logic [15:0] sel_serial_a,
  input wire logic [15:0] sel_serial_b,
  input wire logic        sel_pick_b,
  input wire logic        selector_ok,
  input wire logic        link_enabled,
  input wire logic        enable_refused,
  input wire logic [15:0] tx_serial,
  input wire logic [15:0] rx_serial
);
  // ******
  // shadow of the loaded block size
  // ******
  logic        red;
  logic [7:0]  words;
  logic [7:0]  lim;
  logic [7:0]  rtop;
  logic [15:0] sdiff;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      red   <= 1'b1;
      words <= WORDS_RESET;
    end else if (cfg_load) begin
      red   <= cfg_in.redundant;
      words <= cfg_in.words;
    end
  end
  assign lim = red ? ((words > MAX_WORDS_RED) ? MAX_WORDS_RED : words)
                   : ((words > MAX_WORDS_STD) ? MAX_WORDS_STD : words);
  assign rtop = red ? lim : lim - 8'h01;
  assign sdiff = sel_serial_b - sel_serial_a;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  chk_load_disables: assert property (cfg_load |=> !link_enabled)
    else $error("link still enabled after download");
  chk_run_refused: assert property (
    enable_req && !ctrl_stop && !cfg_load |=>
      enable_refused && link_enabled == $past(link_enabled))
    else $error("enable change taken outside stop mode");
  chk_stop_taken: assert property (
    enable_req && ctrl_stop && !cfg_load |=>
      !enable_refused && link_enabled == $past(enable_value))
    else $error("enable change lost in stop mode");
  chk_tx_holds: assert property (
    tx_valid && !tx_ready && link_enabled && !enable_req && !cfg_load
      |=> tx_valid && $stable(tx_beat))
    else $error("transmit beat dropped while stalled");
  chk_first_serial: assert property (
    tx_valid && tx_beat.first && red && link_enabled
      |-> tx_beat.data == tx_serial)
    else $error("first beat is not the own serial");
  chk_serial_step: assert property (
    $past(reset_n) && tx_serial != $past(tx_serial) && !$past(cfg_load)
      |-> tx_serial == $past(tx_serial) + 16'h0001)
    else $error("own serial moved by other than one");
  chk_store_limit: assert property (
    rx_store.valid |-> rx_store.addr <= rtop)
    else $error("receive word stored past block end");
  chk_rx_serial: assert property (
    rx_store.valid && rx_store.addr == 8'h00 |-> rx_serial == rx_store.data)
    else $error("held serial differs from stored serial");
  chk_flags_or: assert property (
    $past(reset_n) |-> link_flags == $past(flags_a | flags_b))
    else $error("link flags are not the or of both modules");
  chk_sel_pick: assert property (
    $rose(sel_enable) |=> selector_ok
      && sel_pick_b == ($past(sdiff) != 16'h0 && $past(sdiff) < 16'h8000))
    else $error("selector result wrong or late");
endmodule
bind rlbs_top rlbs_chk i_rlbs_chk (.ref_clk, .reset_n, .cfg_load, .cfg_in,
  .ctrl_stop, .enable_req, .enable_value, .tx_valid, .tx_beat, .tx_ready,
  .rx_store, .flags_a, .flags_b, .link_flags, .sel_enable, .sel_serial_a,
  .sel_serial_b, .sel_pick_b, .selector_ok, .link_enabled, .enable_refused,
  .tx_serial, .rx_serial);

// ==== sim/rlbs_link_model.sv ====
// far-side model: takes transmit beats, plays frames from modules a and b
`timescale 1ns/1ps
module rlbs_link_model
  import rlbs_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       tx_valid,
  input  wire rlbs_beat_t tx_beat,
  output logic            tx_ready,
  output logic            rx_a_valid,
  output rlbs_beat_t      rx_a_beat,
  output logic            rx_b_valid,
  output rlbs_beat_t      rx_b_beat
);
  // ******
  // random stalls keep the fifo filling
  // ******
  int         seed = 32'h127a;
  bit         slow = 1'b0;
  rlbs_beat_t got[$];
  logic       v[2] = '{1'b0, 1'b0};
  rlbs_beat_t b[2] = '{'1, '1};
  assign rx_a_valid = v[0];
  assign rx_a_beat  = b[0];
  assign rx_b_valid = v[1];
  assign rx_b_beat  = b[1];
  initial tx_ready = 1'b0;
  always @(posedge ref_clk) begin
    tx_ready <= slow ? 1'($random(seed)) : 1'b1;
    if (reset_n && tx_valid && tx_ready)
      got.push_back(tx_beat);
  end
  // a frame is the serial word then n data words, n at least one
  task automatic send(input bit s_b, input logic [15:0] s, input int n);
    rlbs_beat_t bt;
    for (int i = 0; i <= n; i++) begin
      @(posedge ref_clk);
      bt.first = (i == 0);
      bt.last  = (i == n);
      bt.data  = (i == 0) ? s : {s[7:0], 8'(i)};
      v[s_b] <= 1'b1;
      b[s_b] <= bt;
    end
    @(posedge ref_clk);
    v[s_b] <= 1'b0;
    b[s_b] <= ~bt;
  endtask
endmodule

// ==== sim/testbench.sv ====
// self-checking testbench of the redundant link block selector
`timescale 1ns/1ps
module testbench
  import rlbs_pkg::*;
();
  // ******
  // stimulus and checks
  // ******
  localparam int unsigned PER = 200;
  // worst transfer in cycles: both scans plus the communication scan
  localparam int unsigned SENDER_SCAN_TIME       = 40;
  localparam int unsigned RECEIVER_SCAN_TIME     = 40;
  localparam int unsigned PER_STATION_MEDIA_TIME = 23;
  localparam int unsigned STATION_COUNT          = 2;
  localparam int unsigned COMM_SCAN =
    PER_STATION_MEDIA_TIME * STATION_COUNT;
  localparam int unsigned MAX_TRANSFER_TIME =
    SENDER_SCAN_TIME + RECEIVER_SCAN_TIME + COMM_SCAN;
  localparam logic [15:0] CA [3] = '{16'hffff, 16'h0005, 16'h0001};
  localparam logic [15:0] CB [3] = '{16'h0001, 16'h0005, 16'h8001};
  int          seed = 32'h127a;
  int          n_errors = 0;
  int          checks = 0;
  int          n;
  int          k;
  bit          red;
  logic [15:0] e, fa, fb, sa, sb;
  logic [15:0] mem [60];
  rlbs_wr_t    st[$];
  logic        ref_clk = 1'b0, reset_n = 1'b0, cfg_load = 1'b0;
  rlbs_cfg_t   cfg_in = '0;
  logic        ctrl_stop = 1'b0, enable_req = 1'b0, enable_value = 1'b0;
  logic        tx_wr_en = 1'b0, sel_enable = 1'b0, period_sync = 1'b0;
  logic [7:0]  tx_wr_addr = 8'h00;
  logic [15:0] tx_wr_data = 16'h0, flags_a = 16'h0, flags_b = 16'h0;
  logic [15:0] sel_serial_a = 16'h0, sel_serial_b = 16'h0;
  logic        tx_valid, tx_ready, rx_a_valid, rx_b_valid;
  rlbs_beat_t  tx_beat, rx_a_beat, rx_b_beat;
  rlbs_wr_t    rx_store;
  logic [15:0] link_flags, tx_serial, rx_serial;
  logic        sel_pick_b, selector_ok, link_enabled, enable_refused;
  always #5 ref_clk = ~ref_clk;
  rlbs_top #(.PERIOD(PER)) i_rlbs_top (.ref_clk, .reset_n, .cfg_load,
    .cfg_in, .ctrl_stop, .enable_req, .enable_value, .period_sync,
    .tx_wr_en, .tx_wr_addr, .tx_wr_data, .tx_valid, .tx_beat, .tx_ready,
    .rx_a_valid, .rx_a_beat, .rx_b_valid, .rx_b_beat, .rx_store, .flags_a,
    .flags_b, .link_flags, .sel_enable, .sel_serial_a, .sel_serial_b,
    .sel_pick_b, .selector_ok, .link_enabled, .enable_refused, .tx_serial,
    .rx_serial);
  rlbs_link_model i_link (.ref_clk, .reset_n, .tx_valid, .tx_beat,
    .tx_ready, .rx_a_valid, .rx_a_beat, .rx_b_valid, .rx_b_beat);
  always @(posedge ref_clk)
    if (rx_store.valid) st.push_back(rx_store);
  function automatic logic newer(input logic [15:0] nw, input logic [15:0] h);
    logic [15:0] d;
    d = nw - h;
    return d != 16'h0 && d < 16'h8000;
  endfunction
  function automatic int flen(input bit r, input int w);
    int l;
    l = r ? (w > MAX_WORDS_RED ? MAX_WORDS_RED : w)
          : (w > MAX_WORDS_STD ? MAX_WORDS_STD : w);
    return r ? l + 1 : l;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic req(input logic v);
    @(posedge ref_clk);
    enable_req   <= 1'b1;
    enable_value <= v;
    @(posedge ref_clk);
    enable_req <= 1'b0;
    #1;
  endtask
  task automatic load(input logic r, input logic [7:0] w);
    @(posedge ref_clk);
    cfg_load <= 1'b1;
    cfg_in   <= '{redundant: r, words: w};
    @(posedge ref_clk);
    cfg_load <= 1'b0;
    #1;
  endtask
  task automatic rxexp(input logic [15:0] s, input int base);
    repeat (3) @(posedge ref_clk);
    chk(st.size(), base + 4);
    for (int i = 0; i < 4; i++) begin
      chk(st[base + i].addr, i);
      chk(st[base + i].data, i == 0 ? s : {s[7:0], 8'(i)});
    end
    chk(rx_serial, s);
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    #1 chk(link_enabled, 0);
    chk(tx_serial, SERIAL_RESET);
    repeat (12) begin
      @(posedge ref_clk);
      fa = 16'($random(seed));
      fb = 16'($random(seed));
      flags_a <= fa;
      flags_b <= fb;
      @(posedge ref_clk);
      #1 chk(link_flags, fa | fb);
    end
    req(1'b1);
    chk(enable_refused, 1);
    chk(link_enabled, 0);
    ctrl_stop <= 1'b1;
    req(1'b1);
    chk(link_enabled, 1);
    load(1'b1, 8'd3);
    chk(link_enabled, 0);
    for (int m = 0; m < 2; m++) begin
      red = (m == 0);
      n = flen(red, red ? 70 : 4);
      load(red, red ? 8'd70 : 8'd4);
      for (int i = 0; i < 60; i++) begin
        mem[i] = (!red && i == 0) ? 16'h0001 : 16'($random(seed));
        @(posedge ref_clk);
        tx_wr_en   <= 1'b1;
        tx_wr_addr <= 8'(i);
        tx_wr_data <= mem[i];
      end
      @(posedge ref_clk);
      tx_wr_en <= 1'b0;
      i_link.got.delete();
      i_link.slow = 1'b1;
      req(1'b1);
      if (red) begin
        // partner pulse restarts the period, so no tick yet
        repeat (150) @(posedge ref_clk);
        period_sync <= 1'b1;
        @(posedge ref_clk);
        period_sync <= 1'b0;
        repeat (100) @(posedge ref_clk);
        #1 chk(tx_serial, SERIAL_RESET);
      end
      for (k = 0; k < 3000 && i_link.got.size() < n; k++)
        @(posedge ref_clk);
      chk(k < PER + MAX_TRANSFER_TIME, 1);
      req(1'b0);
      chk(i_link.got[0].first, 1);
      for (int i = 0; i < n; i++) begin
        e = (red && i == 0) ? 16'h0001 : mem[red ? i - 1 : i];
        chk(i_link.got[i].data, e);
        chk(i_link.got[i].last, i == n - 1);
      end
    end
    load(1'b1, 8'd3);
    st.delete();
    req(1'b1);
    i_link.send(1'b0, 16'h0005, 3);
    rxexp(16'h0005, 0);
    i_link.send(1'b1, 16'h0004, 3);
    repeat (3) @(posedge ref_clk);
    chk(st.size(), 4);
    fork
      i_link.send(1'b0, 16'h0006, 5);
      i_link.send(1'b1, 16'h0006, 5);
    join
    rxexp(16'h0006, 4);
    i_link.send(1'b1, 16'h0007, 3);
    rxexp(16'h0007, 8);
    fork
      i_link.send(1'b0, 16'h0008, 3);
      i_link.send(1'b1, 16'h0009, 3);
    join
    rxexp(16'h0009, 12);
    for (int i = 0; i < 8; i++) begin
      sa = i < 3 ? CA[i] : 16'($random(seed));
      sb = i < 3 ? CB[i] : 16'($random(seed));
      @(posedge ref_clk);
      sel_serial_a <= sa;
      sel_serial_b <= sb;
      sel_enable   <= 1'b1;
      @(posedge ref_clk);
      #1 chk(selector_ok, 1);
      chk(sel_pick_b, newer(sb, sa));
      @(posedge ref_clk);
      sel_enable <= 1'b0;
      @(posedge ref_clk);
    end
    complete_run();
  end
  // generous bound: the sequence needs about a thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    complete_run();
  end
endmodule
